// ==== include/stim_select_defines.vh ====
// Offsets, field layout, reset values and sizes of the stimulus select bank
`ifndef STIM_SELECT_DEFINES_VH
`define STIM_SELECT_DEFINES_VH

// ==========================================================================
// Sizes
`define PORT_COUNT      256
`define PORT_BITS       8
`define GROUP_BITS      3
`define GSEL_W          4
`define MASTER_BITS     2
`define MSEL_W          3
`define UMASK_W         32
`define PORT_IN_GROUP_W 5

// ==========================================================================
// Byte offsets on the register bus
`define OFF_PORT_ENABLE   12'he00
`define OFF_PORT_TRIGGER  12'he20
`define OFF_USER_MASK     12'he40
`define OFF_GROUP_SELECT  12'he60
`define OFF_MASTER_SELECT 12'he64
`define OFF_ACTIVITY      12'ha00

// ==========================================================================
// Field positions
`define GSEL_CTL_LSB  0
`define GSEL_FLD_LSB  20
`define MSEL_CTL_BIT  0
`define MSEL_FLD_LSB  15

// ==========================================================================
// Group select control codes
`define GCTL_UNUSED  2'b00
`define GCTL_TRIG    2'b01
`define GCTL_BOTH    2'b11

// ==========================================================================
// Reset values
`define RST_PORT_ENABLE  32'h0000_0000
`define RST_PORT_TRIGGER 32'h0000_0000
`define RST_USER_MASK    32'h0000_0000
`define RST_GSEL_CTL     2'b00
`define RST_GSEL_FLD     4'h0
`define RST_MSEL_CTL     1'b0
`define RST_MSEL_FLD     3'h0

`endif

// ==== rtl/sel_decode.v ====
// Decoder for the trailing-zero mask, delimiter and index select encoding
`timescale 1ns/10ps

module sel_decode #(
  parameter W = 4
) (
  sel_value,
  index,
  hit
);
  input  wire [W-1:0] sel_value;
  input  wire [W-2:0] index;
  output wire         hit;

  // ========================================================================
  // Match
  // Ones from bit 0 up to the lowest set bit: those bits are don't care
  wire [W-1:0] care_n;
  wire [W-1:0] probe;

  assign care_n = sel_value ^ (sel_value - {{(W-1){1'b0}}, 1'b1});
  assign probe  = {index, 1'b1};
  // Only top bit set leaves every bit as don't care: all selected
  assign hit    = ~|((probe ^ sel_value) & ~care_n);
endmodule

// ==== rtl/port_qualify.v ====
// Decides trace and trigger for one stimulus port write
`timescale 1ns/10ps
`include "stim_select_defines.vh"

module port_qualify (
  port_enable,
  port_trigger,
  user_mask,
  group_ctl,
  group_hit,
  master_ctl,
  master_hit,
  port,
  user_mode,
  trace_ok,
  trigger_ok,
  user_blocked
);
  input  wire [31:0]             port_enable;
  input  wire [31:0]             port_trigger;
  input  wire [`UMASK_W-1:0]     user_mask;
  input  wire [1:0]              group_ctl;
  input  wire                    group_hit;
  input  wire                    master_ctl;
  input  wire                    master_hit;
  input  wire [`PORT_BITS-1:0]   port;
  input  wire                    user_mode;
  output wire                    trace_ok;
  output wire                    trigger_ok;
  output wire                    user_blocked;

  // ========================================================================
  // Qualification
  wire [`PORT_IN_GROUP_W-1:0] bit_idx;
  wire master_ok;
  wire en_group_ok;
  wire trig_group_ok;
  wire enabled;

  assign bit_idx       = port[`PORT_IN_GROUP_W-1:0];         // [R9]
  assign master_ok     = ~master_ctl | master_hit;           // [R18] [R19]
  assign en_group_ok   = (group_ctl != `GCTL_BOTH) | group_hit;   // [R14]
  assign trig_group_ok = ((group_ctl != `GCTL_TRIG) &&
                          (group_ctl != `GCTL_BOTH)) | group_hit; // [R13]
  assign enabled       = port_enable[bit_idx] & en_group_ok &
                         master_ok;                          // [R23]
  // One mask bit per eight ports
  assign user_blocked  = user_mode &
                         user_mask[port[`PORT_BITS-1:3]];    // [R1] [R2]
  assign trace_ok      = enabled & ~user_blocked;            // [R22]
  // Trigger never without enable
  assign trigger_ok    = trace_ok & port_trigger[bit_idx] &
                         trig_group_ok;                      // [R15] [R24]
endmodule

// ==== rtl/stim_select.v ====
// Stimulus port access, group and master selection register bank
//
// Function
// [R1] Set user-mask bit ignores user accesses
// [R2] Mask bit n covers ports 8n..8n+7
// [R3] Mask width is ports over eight
// [R4] Mask covers 256 ports, resets to zero
// [R5] Mask written only when privileged or debugger
// [R6] Group select absent at 32 ports or fewer
// [R7] Group control low two bits, resets 00
// [R8] Group field at bits 31:20
// [R9] Unused selection repeats masks every 32 ports
// [R10] Trailing zeros mask, delimiter, then group
// [R11] Top bit only selects all ports
// [R12] Software avoids zero or oversize group select
// [R13] Control 01 limits triggers to selected groups
// [R14] Control 11 limits enable and trigger
// [R15] No trigger on a disabled port
// [R16] Master select absent with one master
// [R17] Master field 31:15, control bit 0
// [R18] Control zero applies to all masters
// [R19] Control one disables unselected masters
// [R20] Master value uses same encoding
// [R21] Software avoids zero or oversize master select
// [R22] Trace only when enabled and not blocked
// [R23] Enable mask one bit per port, reset zero
// [R24] Trigger mask one bit per port, reset zero
`timescale 1ns/10ps
`include "stim_select_defines.vh"

module stim_select (
  core_clk,
  reset,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  bus_privileged,
  stim_valid,
  stim_port,
  stim_master,
  stim_user,
  trace_valid,
  trace_port,
  trace_master,
  trigger_pulse,
  user_reject
);
  input  wire                     core_clk;
  input  wire                     reset;
  input  wire                     wb_cyc_i;
  input  wire                     wb_stb_i;
  input  wire                     wb_we_i;
  input  wire [11:0]              wb_adr_i;
  input  wire [3:0]               wb_sel_i;
  input  wire [31:0]              wb_dat_i;
  output wire [31:0]              wb_dat_o;
  output wire                     wb_ack_o;
  input  wire                     bus_privileged;
  input  wire                     stim_valid;
  input  wire [`PORT_BITS-1:0]    stim_port;
  input  wire [`MASTER_BITS-1:0]  stim_master;
  input  wire                     stim_user;
  output wire                     trace_valid;
  output wire [`PORT_BITS-1:0]    trace_port;
  output wire [`MASTER_BITS-1:0]  trace_master;
  output wire                     trigger_pulse;
  output wire                     user_reject;

  // ========================================================================
  // Bus states
  localparam S_IDLE = 1'b0;
  localparam S_ACK  = 1'b1;

  // ========================================================================
  // Storage
  reg  [31:0]             port_enable_reg;
  reg  [31:0]             port_trigger_reg;
  reg  [`UMASK_W-1:0]     user_block_mask_reg;
  reg  [1:0]              group_select_ctl_reg;
  reg  [`GSEL_W-1:0]      group_select_field_reg;
  reg                     master_select_ctl_reg;
  reg  [`MSEL_W-1:0]      master_select_field_reg;
  reg  [15:0]             traced_count_reg;
  reg  [15:0]             reject_count_reg;
  reg                     state_reg;
  reg                     state_next;
  reg  [31:0]             rdata_reg;
  reg  [31:0]             rdata_next;
  reg                     trace_valid_reg;
  reg  [`PORT_BITS-1:0]   trace_port_reg;
  reg  [`MASTER_BITS-1:0] trace_master_reg;
  reg                     trigger_reg;
  reg                     reject_reg;

  // ========================================================================
  // Address decode
  wire        req;
  wire        wr_take;
  wire [31:0] bmask;
  wire        hit_enable;
  wire        hit_trigger;
  wire        hit_user;
  wire        hit_group;
  wire        hit_master;
  wire        hit_activity;
  wire [11:0] word_adr;

  // Low address bits never split a register: compare whole words
  assign word_adr     = {wb_adr_i[11:2], 2'b00};

  assign req          = wb_cyc_i & wb_stb_i & (state_reg == S_IDLE);
  assign wr_take      = req & wb_we_i;
  assign hit_enable   = word_adr == `OFF_PORT_ENABLE;
  assign hit_trigger  = word_adr == `OFF_PORT_TRIGGER;
  assign hit_user     = word_adr == `OFF_USER_MASK;
  // Present only because ports exceed 32 and masters exceed one
  assign hit_group    = word_adr == `OFF_GROUP_SELECT;  // [R6]
  assign hit_master   = word_adr == `OFF_MASTER_SELECT; // [R16]
  assign hit_activity = word_adr == `OFF_ACTIVITY;

  // Per-lane write mask built from the byte selects
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign bmask[lane*8+7:lane*8] = {8{wb_sel_i[lane]}};
    end
  endgenerate

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] m;
    begin
      merge = (old_v & ~m) | (new_v & m);
    end
  endfunction

  // ========================================================================
  // Bus handshake: one wait state, ack for exactly one cycle
  // S_ACK ignores cyc, so back-to-back requests see one idle cycle
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          state_next = S_ACK;
        end
      end
      S_ACK: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // ========================================================================
  // Read mux; unmapped offsets read zero
  always @* begin
    rdata_next = 32'h0000_0000;
    if (hit_enable) begin
      rdata_next = port_enable_reg;
    end else if (hit_trigger) begin
      rdata_next = port_trigger_reg;
    end else if (hit_user) begin
      rdata_next = user_block_mask_reg;                     // [R3] [R4]
    end else if (hit_group) begin
      // Reserved middle bits and unbuilt field bits read zero
      rdata_next[`GSEL_FLD_LSB+`GSEL_W-1:`GSEL_FLD_LSB] =
        group_select_field_reg;                             // [R8]
      rdata_next[`GSEL_CTL_LSB+1:`GSEL_CTL_LSB] =
        group_select_ctl_reg;                               // [R7]
    end else if (hit_master) begin
      rdata_next[`MSEL_FLD_LSB+`MSEL_W-1:`MSEL_FLD_LSB] =
        master_select_field_reg;                            // [R17]
      rdata_next[`MSEL_CTL_BIT] = master_select_ctl_reg;   // [R17]
    end else if (hit_activity) begin
      rdata_next = {reject_count_reg, traced_count_reg};
    end
  end

  // ========================================================================
  // Register writes
  wire [31:0] gsel_img;
  wire [31:0] msel_img;
  wire [31:0] gsel_new;
  wire [31:0] msel_new;
  wire [31:0] user_new;
  wire        user_wr_ok;

  assign gsel_img = {{(32-`GSEL_FLD_LSB-`GSEL_W){1'b0}},
                     group_select_field_reg,
                     {(`GSEL_FLD_LSB-2){1'b0}},
                     group_select_ctl_reg};
  assign msel_img = {{(32-`MSEL_FLD_LSB-`MSEL_W){1'b0}},
                     master_select_field_reg,
                     {(`MSEL_FLD_LSB-1){1'b0}},
                     master_select_ctl_reg};
  assign gsel_new = merge(gsel_img, wb_dat_i, bmask);
  assign msel_new = merge(msel_img, wb_dat_i, bmask);
  assign user_new = merge(user_block_mask_reg, wb_dat_i, bmask);
  // Unprivileged writes are acked but leave the mask alone
  assign user_wr_ok = hit_user & bus_privileged;             // [R5]

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_enable_reg         <= `RST_PORT_ENABLE;      // [R23]
      port_trigger_reg        <= `RST_PORT_TRIGGER;     // [R24]
      user_block_mask_reg     <= `RST_USER_MASK;        // [R4]
      group_select_ctl_reg    <= `RST_GSEL_CTL;         // [R7]
      // Field resets are undefined; zero keeps simulation clean
      group_select_field_reg  <= `RST_GSEL_FLD;
      master_select_ctl_reg   <= `RST_MSEL_CTL;         // [R17]
      master_select_field_reg <= `RST_MSEL_FLD;
    end else if (wr_take) begin
      if (hit_enable) begin
        port_enable_reg <= merge(port_enable_reg, wb_dat_i, bmask);
      end
      if (hit_trigger) begin
        port_trigger_reg <= merge(port_trigger_reg, wb_dat_i, bmask);
      end
      if (user_wr_ok) begin
        user_block_mask_reg <= user_new;                  // [R5]
      end
      if (hit_group) begin
        // Reserved code 10 is kept and decodes as unused
        group_select_ctl_reg   <= gsel_new[`GSEL_CTL_LSB+1:`GSEL_CTL_LSB];
        group_select_field_reg <=
          gsel_new[`GSEL_FLD_LSB+`GSEL_W-1:`GSEL_FLD_LSB]; // [R8]
      end
      if (hit_master) begin
        master_select_ctl_reg   <= msel_new[`MSEL_CTL_BIT];
        master_select_field_reg <=
          msel_new[`MSEL_FLD_LSB+`MSEL_W-1:`MSEL_FLD_LSB]; // [R17]
      end
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= S_IDLE;
      rdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (req) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign wb_ack_o = state_reg;
  assign wb_dat_o = rdata_reg;

  // ========================================================================
  // Group and master selection
  wire group_hit;
  wire master_hit;
  wire trace_ok;
  wire trigger_ok;
  wire user_blocked;

  // Zero field with its control set selects all; software must avoid it
  sel_decode #(
    .W (`GSEL_W)
  ) u_group_decode (
    .sel_value (group_select_field_reg),
    .index     (stim_port[`PORT_BITS-1:`PORT_IN_GROUP_W]),
    .hit       (group_hit)                                 // [R10] [R11]
  );

  sel_decode #(
    .W (`MSEL_W)
  ) u_master_decode (
    .sel_value (master_select_field_reg),
    .index     (stim_master),
    .hit       (master_hit)                                // [R20]
  );

  port_qualify u_qualify (
    .port_enable  (port_enable_reg),
    .port_trigger (port_trigger_reg),
    .user_mask    (user_block_mask_reg),
    .group_ctl    (group_select_ctl_reg),
    .group_hit    (group_hit),
    .master_ctl   (master_select_ctl_reg),
    .master_hit   (master_hit),
    .port         (stim_port),
    .user_mode    (stim_user),
    .trace_ok     (trace_ok),
    .trigger_ok   (trigger_ok),
    .user_blocked (user_blocked)
  );

  // ========================================================================
  // Qualified write outputs, one cycle after the stimulus write
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trace_valid_reg  <= 1'b0;
      trace_port_reg   <= {`PORT_BITS{1'b0}};
      trace_master_reg <= {`MASTER_BITS{1'b0}};
      trigger_reg      <= 1'b0;
      reject_reg       <= 1'b0;
    end else begin
      trace_valid_reg <= stim_valid & trace_ok;            // [R22]
      trigger_reg     <= stim_valid & trigger_ok;          // [R15]
      reject_reg      <= stim_valid & user_blocked;        // [R1]
      if (stim_valid) begin
        trace_port_reg   <= stim_port;
        trace_master_reg <= stim_master;
      end
    end
  end

  // Saturating so software never sees a wrap to small values
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      traced_count_reg <= 16'h0000;
      reject_count_reg <= 16'h0000;
    end else begin
      if (trace_valid_reg && traced_count_reg != 16'hffff) begin
        traced_count_reg <= traced_count_reg + 16'h0001;
      end
      if (reject_reg && reject_count_reg != 16'hffff) begin
        reject_count_reg <= reject_count_reg + 16'h0001;
      end
    end
  end

  assign trace_valid   = trace_valid_reg;
  assign trace_port    = trace_port_reg;
  assign trace_master  = trace_master_reg;
  assign trigger_pulse = trigger_reg;
  assign user_reject   = reject_reg;
endmodule

// ==== verif/stim_select_properties.sv ====
// Checker for the stimulus select bank ports
`timescale 1ns/10ps
`include "stim_select_defines.vh"

module stim_select_properties (
  input wire                    core_clk,
  input wire                    reset,
  input wire                    wb_cyc_i,
  input wire                    wb_stb_i,
  input wire                    wb_ack_o,
  input wire                    stim_valid,
  input wire [`PORT_BITS-1:0]   stim_port,
  input wire [`MASTER_BITS-1:0] stim_master,
  input wire                    stim_user,
  input wire                    trace_valid,
  input wire [`PORT_BITS-1:0]   trace_port,
  input wire [`MASTER_BITS-1:0] trace_master,
  input wire                    trigger_pulse,
  input wire                    user_reject
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Sequences
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence priv_write;
    stim_valid && !stim_user;
  endsequence

  // ==========================================================
  // Register bus
  wb_answer_a:
    assert property (wb_req |=> wb_ack_o)
    else $error("request not acked next cycle");
  ack_once_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_cause_a:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");

  // ==========================================================
  // Stimulus path
  quiet_idle_a:
    assert property (!stim_valid |=>
      !(trace_valid || trigger_pulse || user_reject))
    else $error("pulse without stimulus write");
  trig_traced_a:
    assert property (trigger_pulse |-> trace_valid)
    else $error("trigger on untraced write");
  reject_blocks_a:
    assert property (user_reject |-> !trace_valid)
    else $error("rejected write traced");
  priv_pass_a:
    assert property (priv_write |=> !user_reject)
    else $error("privileged write rejected");
  trace_tag_a:
    assert property (stim_valid |=> trace_port == $past(stim_port)
      && trace_master == $past(stim_master))
    else $error("trace port or master wrong");
  trace_hold_a:
    assert property (!stim_valid |=>
      $stable(trace_port) && $stable(trace_master))
    else $error("trace tag moved without write");
endmodule

bind stim_select stim_select_properties i_stim_select_properties (
  .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .stim_valid(stim_valid),
  .stim_port(stim_port), .stim_master(stim_master),
  .stim_user(stim_user), .trace_valid(trace_valid),
  .trace_port(trace_port), .trace_master(trace_master),
  .trigger_pulse(trigger_pulse), .user_reject(user_reject));

// ==== verif/stim_source.sv ====
// Behavioural bus master issuing stimulus port writes
`timescale 1ns/10ps
`include "stim_select_defines.vh"

module stim_source (
  input  wire                     core_clk,
  output logic                    stim_valid,
  output logic [`PORT_BITS-1:0]   stim_port,
  output logic [`MASTER_BITS-1:0] stim_master,
  output logic                    stim_user
);
  initial begin
    stim_valid = 1'b0;
    stim_port = 8'h00;
    stim_master = 2'h0;
    stim_user = 1'b0;
  end

  // Released lines flip so a stale value cannot pass for a match
  task automatic send(input logic [7:0] p, input logic [1:0] m,
                      input logic u);
    @(posedge core_clk);
    stim_valid <= 1'b1;
    stim_port <= p;
    stim_master <= m;
    stim_user <= u;
    @(posedge core_clk);
    stim_valid <= 1'b0;
    stim_port <= ~p;
    stim_master <= ~m;
    stim_user <= ~u;
  endtask
endmodule

// ==== verif/stim_select_bench.sv ====
// Self-checking bench for the stimulus select bank
`timescale 1ns/10ps
`include "stim_select_defines.vh"

module stim_select_bench;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic        bus_privileged = 1'b1;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, stim_valid, stim_user, trace_valid;
  wire  [7:0]  stim_port, trace_port;
  wire  [1:0]  stim_master, trace_master;
  wire         trigger_pulse, user_reject;
  int          num_errors = 0;
  int          check_count = 0;
  logic [3:0]  lane_sel = 4'hf;

  always #5 core_clk = ~core_clk;

  stim_select i_stim_select (.core_clk(core_clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bus_privileged(bus_privileged), .stim_valid(stim_valid),
    .stim_port(stim_port), .stim_master(stim_master),
    .stim_user(stim_user), .trace_valid(trace_valid),
    .trace_port(trace_port), .trace_master(trace_master),
    .trigger_pulse(trigger_pulse), .user_reject(user_reject));

  stim_source i_stim_source (.core_clk(core_clk),
    .stim_valid(stim_valid), .stim_port(stim_port),
    .stim_master(stim_master), .stim_user(stim_user));

  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= lane_sel;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      $display("mismatch ack expected 1 seen %b", wb_ack_o);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check($sformatf("reg %h", a), e, q);
  endtask

  // Expected result bits: trace, trigger, reject
  task automatic st(input logic [7:0] p, input logic [1:0] m,
                    input logic u, input logic [2:0] e);
    i_stim_source.send(p, m, u);
    #1;
    check($sformatf("port %0d master %0d", p, m), {29'h0, e},
          {29'h0, trace_valid, trigger_pulse, user_reject});
    check("trace tag", {22'h0, m, p},
          {22'h0, trace_master, trace_port});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(`OFF_PORT_ENABLE, 32'h0000_0000);
    rd(`OFF_PORT_TRIGGER, 32'h0000_0000);
    rd(`OFF_USER_MASK, 32'h0000_0000);
    rd(`OFF_GROUP_SELECT, 32'h0000_0000);
    rd(`OFF_MASTER_SELECT, 32'h0000_0000);
    rd(12'h100, 32'h0000_0000);
    rd(`OFF_ACTIVITY, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_user;
    wr(`OFF_PORT_ENABLE, 32'h0181_0000);
    bus_privileged <= 1'b0;
    wr(`OFF_USER_MASK, 32'h0000_0004);
    rd(`OFF_USER_MASK, 32'h0000_0000);
    bus_privileged <= 1'b1;
    wr(`OFF_USER_MASK, 32'h0000_0004);
    rd(`OFF_USER_MASK, 32'h0000_0004);
    st(8'd16, 2'd0, 1'b1, 3'b001);
    st(8'd23, 2'd3, 1'b1, 3'b001);
    st(8'd16, 2'd0, 1'b0, 3'b100);
    st(8'd24, 2'd0, 1'b1, 3'b100);
    wr(`OFF_USER_MASK, 32'h0000_0000);
    $display("test user mask done");
  endtask

  task automatic t_groups;
    int i;
    logic [7:0] ports [3] = '{8'd0, 8'd32, 8'd224};
    wr(`OFF_PORT_ENABLE, 32'h0000_0001);
    wr(`OFF_PORT_TRIGGER, 32'h0000_0001);
    for (i = 0; i < 3; i++) st(ports[i], 2'd1, 1'b0, 3'b110);
    st(8'd1, 2'd0, 1'b0, 3'b000);
    wr(`OFF_GROUP_SELECT, 32'h0030_0001);
    st(8'd32, 2'd0, 1'b0, 3'b110);
    st(8'd0, 2'd0, 1'b0, 3'b100);
    wr(`OFF_GROUP_SELECT, 32'h0030_0002);
    st(8'd0, 2'd0, 1'b0, 3'b110);
    wr(`OFF_GROUP_SELECT, 32'h0030_0003);
    st(8'd32, 2'd2, 1'b0, 3'b110);
    st(8'd64, 2'd0, 1'b0, 3'b000);
    wr(`OFF_GROUP_SELECT, 32'h0060_0003);
    st(8'd96, 2'd0, 1'b0, 3'b110);
    st(8'd128, 2'd0, 1'b0, 3'b000);
    wr(`OFF_GROUP_SELECT, 32'h0080_0003);
    st(8'd192, 2'd0, 1'b0, 3'b110);
    $display("test groups done");
  endtask

  task automatic t_masters;
    wr(`OFF_GROUP_SELECT, 32'h0030_0003);
    wr(`OFF_MASTER_SELECT, 32'h0001_8001);
    st(8'd32, 2'd1, 1'b0, 3'b110);
    st(8'd32, 2'd2, 1'b0, 3'b000);
    wr(`OFF_MASTER_SELECT, 32'h0003_0001);
    st(8'd32, 2'd3, 1'b0, 3'b110);
    st(8'd32, 2'd1, 1'b0, 3'b000);
    wr(`OFF_MASTER_SELECT, 32'h0001_8000);
    st(8'd32, 2'd2, 1'b0, 3'b110);
    wr(`OFF_MASTER_SELECT, 32'h0002_0001);
    st(8'd32, 2'd0, 1'b0, 3'b110);
    wr(`OFF_GROUP_SELECT, 32'hffff_ffff);
    rd(`OFF_GROUP_SELECT, 32'h00f0_0003);
    wr(`OFF_MASTER_SELECT, 32'hffff_ffff);
    rd(`OFF_MASTER_SELECT, 32'h0003_8001);
    $display("test masters done");
  endtask

  task automatic t_trig_off;
    wr(`OFF_GROUP_SELECT, 32'h0000_0000);
    wr(`OFF_MASTER_SELECT, 32'h0000_0000);
    wr(`OFF_PORT_TRIGGER, 32'h0000_0002);
    st(8'd1, 2'd0, 1'b0, 3'b000);
    st(8'd0, 2'd0, 1'b0, 3'b100);
    lane_sel = 4'h2;
    wr(`OFF_PORT_TRIGGER, 32'hffff_ffff);
    lane_sel = 4'hf;
    rd(`OFF_PORT_TRIGGER, 32'h0000_ff02);
    rd(`OFF_ACTIVITY, 32'h0002_0010);
    $display("test disabled trigger done");
  endtask

  // ==========================================================
  // Run control
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    $display("mismatch watchdog expected done seen timeout");
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_user();
    t_groups();
    t_masters();
    t_trig_off();
    give_verdict();
  end
endmodule
